// [rtl/nfc_cfg.svh]
// constants for the normalized fixed/float converter
`ifndef NFC_CFG_SVH
`define NFC_CFG_SVH
`define NFC_LAT 2
`define NFC_SIGN_BIT 31
`define NFC_EXP_HI 30
`define NFC_EXP_LO 23
`define NFC_MAN_W 23
`define NFC_BIAS 8'h7F
`define NFC_FRAC_W 32
`define NFC_ONE 32'h3F800000
`define NFC_NEG_ONE 32'hBF800000
`define NFC_PINF 32'h7F800000
`define NFC_QNAN 32'h7FC00000
`define NFC_ZERO 32'h00000000
`define NFC_B_DEF 8
`define NFC_B_MIN 2
`define NFC_B_MAX 24
`endif

// [rtl/nfc_pkg.sv]
// types for the normalized fixed/float converter
package nfc_pkg;
  typedef enum logic [2:0] {
    NFC_OP_UN2F = 3'b000,
    NFC_OP_SN2F = 3'b001,
    NFC_OP_F2UN = 3'b010,
    NFC_OP_F2SN = 3'b011,
    NFC_OP_SNCL = 3'b100,
    NFC_OP_F2UF = 3'b101,
    NFC_OP_MUL = 3'b110,
    NFC_OP_NOP = 3'b111
  } nfc_op_t;
endpackage : nfc_pkg

// [rtl/nfc_scale.sv]
// float to normalized code: clamp, scale and round to nearest
`timescale 1ns/1ps
`include "nfc_cfg.svh"
module nfc_scale #(
  parameter int B = `NFC_B_DEF
) (
  input wire logic [31:0] f,
  input wire logic sgn_mode,
  output logic [B-1:0] code
);
  localparam int FW = `NFC_FRAC_W;
  localparam int PW = FW + B + 2;
  localparam logic [B:0] UMAX = {1'b0, {B{1'b1}}};
  localparam logic [B:0] SMAX = {2'b00, {(B-1){1'b1}}};

  wire logic neg = f[`NFC_SIGN_BIT];
  wire logic [7:0] ex = f[`NFC_EXP_HI:`NFC_EXP_LO];
  wire logic is_nan = (&ex) && (|f[`NFC_MAN_W-1:0]);
  // denormals and zeros flush to zero so the answer stays deterministic
  wire logic is_zero = (ex == 8'h00) || is_nan || (neg && !sgn_mode); // RULE_05 RULE_15
  wire logic big = (ex >= `NFC_BIAS); // RULE_05 RULE_07
  wire logic [7:0] sh = `NFC_BIAS - ex;
  wire logic [FW:0] fx_raw = {1'b1, f[`NFC_MAN_W-1:0], {(FW-`NFC_MAN_W){1'b0}}} >> sh;
  wire logic [FW:0] fx = is_zero ? '0 : (big ? {1'b1, {FW{1'b0}}} : fx_raw);
  wire logic [B:0] dmul = sgn_mode ? SMAX : UMAX; // RULE_05 RULE_07
  wire logic [PW-1:0] prod = PW'(fx) * PW'(dmul);
  // exact products land on an integer and the half-add leaves them alone
  wire logic [PW-1:0] rnd = prod + PW'({1'b1, {(FW-1){1'b0}}}); // RULE_06 RULE_08
  wire logic [B-1:0] mag = rnd[FW+B-1:FW];

  assign code = (sgn_mode && neg) ? B'(~mag + 1'b1) : mag; // RULE_08 RULE_09
endmodule : nfc_scale

// [rtl/nfc_top.sv]
// normalized fixed/float conversion and float multiply datapath
// What this block does
// RULE_01: unsigned code divided by all-ones, float
// RULE_02: signed code over max, floored at -1
// RULE_03: most negative signed code gives -1.0
// RULE_04: filtered signed values clamp to -1.0
// RULE_05: float clamps to [0,1], scales, rounds
// RULE_06: exact integers kept; 0,1 give 0,max
// RULE_07: float clamps to [-1,1], scales, rounds
// RULE_08: -1,0,1 give -max, 0, max exactly
// RULE_09: codes are two's complement or binary
// RULE_10: float rounding either neighbour, overflow inf
// RULE_11: unsigned float: negatives zero, specials kept
// RULE_12: single precision, range beyond two^32
// RULE_13: times zero, times one identities exact; a denormal times one gives signed zero
// RULE_14: infinity and nan handled, never undefined
// RULE_15: denormals and negative zero deterministic
// RULE_16: no divide stalls, no traps
// RULE_17: width parameter, valid in, fixed latency
`timescale 1ns/1ps
`include "nfc_cfg.svh"
module nfc_top #(
  parameter int B = `NFC_B_DEF
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic IN_VALID,
  input wire logic [2:0] IN_OP,
  input wire logic [31:0] IN_A,
  input wire logic [31:0] IN_B,
  input wire logic [B-1:0] IN_CODE,
  output logic OUT_VALID,
  output logic [31:0] OUT_FLOAT,
  output logic [B-1:0] OUT_CODE
);

  ////////////////////////////////////////////////////////////////////////////
  // parameter check and constants

  if (B < `NFC_B_MIN || B > `NFC_B_MAX) begin : g_bad_width
    $error("nfc_top: B must lie in 2..24 for exact float conversion");
  end

  localparam logic [B-1:0] UMAX = '1;
  localparam logic [B-1:0] SMAX = {1'b0, {(B-1){1'b1}}};
  localparam logic [B-1:0] SMIN = {1'b1, {(B-1){1'b0}}};
  localparam logic [B-1:0] SNEG = SMIN + 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // c / (2^w - 1) is the binary fraction 0.ccc... repeating with period w,
  // so no divider is needed and nothing can stall on a zero divisor
  function automatic logic [31:0] norm_to_float(input logic [23:0] mag, input int w);
    logic [47:0] pat;
    logic [47:0] shd;
    logic [5:0] lz;
    logic found;
    logic [24:0] m25;
    logic [7:0] ex;
    pat = '0;
    lz = '0;
    found = 1'b0;
    for (int i = 0; i < 48; i++) begin
      pat[47-i] = mag[w-1-(i%w)]; // RULE_01 RULE_16
    end
    for (int i = 47; i >= 0; i--) begin
      if (!found && pat[i]) begin
        found = 1'b1;
        lz = 6'(47 - i);
      end
    end
    shd = pat << lz;
    m25 = {2'b01, shd[46:24]} + {24'h000000, shd[23]}; // RULE_10
    ex = `NFC_BIAS - 8'h01 - {2'b00, lz};
    if (m25[24]) begin
      ex = ex + 8'h01;
    end
    if (mag == 24'h000000) begin
      norm_to_float = `NFC_ZERO;
    end else if (mag == 24'((24'h000001 << w) - 24'h000001)) begin
      norm_to_float = `NFC_ONE; // RULE_01
    end else begin
      norm_to_float = {1'b0, ex, m25[22:0]};
    end
  endfunction : norm_to_float

  // single precision multiply, truncating, denormal inputs read as zero
  function automatic logic [31:0] fmul(input logic [31:0] x, input logic [31:0] y);
    logic s;
    logic [7:0] ex;
    logic [7:0] ey;
    logic xz;
    logic yz;
    logic xi;
    logic yi;
    logic xn;
    logic yn;
    logic [47:0] p;
    logic [9:0] e;
    logic [22:0] m;
    s = x[31] ^ y[31];
    ex = x[30:23];
    ey = y[30:23];
    xz = (ex == 8'h00);
    yz = (ey == 8'h00);
    xn = (&ex) && (|x[22:0]);
    yn = (&ey) && (|y[22:0]);
    xi = (&ex) && !(|x[22:0]);
    yi = (&ey) && !(|y[22:0]);
    p = {24'h000000, 1'b1, x[22:0]} * {24'h000000, 1'b1, y[22:0]};
    e = {2'b00, ex} + {2'b00, ey} - 10'h07F + {9'h000, p[47]};
    m = p[47] ? p[46:24] : p[45:23];
    if (xn || yn || (xi && yz) || (yi && xz)) begin
      fmul = `NFC_QNAN; // RULE_14
    end else if (xi || yi) begin
      fmul = {s, 31'(`NFC_PINF)}; // RULE_14
    end else if (xz || yz) begin
      fmul = {s, 31'h00000000}; // RULE_13 RULE_15
    end else if (e[9] || e == 10'h000) begin
      fmul = {s, 31'h00000000};
    end else if (e >= 10'h0FF) begin
      fmul = {s, 31'(`NFC_PINF)}; // RULE_10 RULE_12
    end else begin
      fmul = {s, e[7:0], m}; // RULE_13
    end
  endfunction : fmul

  ////////////////////////////////////////////////////////////////////////////
  // stage one: operand capture

  logic v1_r;
  nfc_pkg::nfc_op_t op1_r;
  logic [31:0] a1_r;
  logic [31:0] b1_r;
  logic [B-1:0] c1_r;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      v1_r <= 1'b0;
      op1_r <= nfc_pkg::NFC_OP_NOP;
      a1_r <= '0;
      b1_r <= '0;
      c1_r <= '0;
    end else begin
      v1_r <= IN_VALID; // RULE_17
      op1_r <= nfc_pkg::nfc_op_t'(IN_OP);
      a1_r <= IN_A;
      b1_r <= IN_B;
      c1_r <= IN_CODE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stage two: conversion datapath

  wire logic c_neg = c1_r[B-1];
  wire logic [B-1:0] c_abs = c_neg ? B'(~c1_r + 1'b1) : c1_r; // RULE_09
  // SMIN negates to itself, so anything at or below -max takes -1.0
  wire logic sn_floor = c_neg && (c1_r == SMIN || c1_r == SNEG); // RULE_02 RULE_03
  wire logic [31:0] un_f = norm_to_float(24'(c1_r), B); // RULE_01
  wire logic [31:0] sn_mag = norm_to_float(24'(c_abs), B - 1); // RULE_02
  wire logic [31:0] sn_f = sn_floor ? `NFC_NEG_ONE : {c_neg, sn_mag[30:0]}; // RULE_02 RULE_03

  wire logic a_nan = (&a1_r[30:23]) && (|a1_r[22:0]);
  wire logic a_below = a1_r[31] && (a1_r[30:0] > 31'(`NFC_ONE));
  wire logic [31:0] cl_f = (a_below && !a_nan) ? `NFC_NEG_ONE : a1_r; // RULE_04
  wire logic [31:0] uf_f = a_nan ? a1_r : (a1_r[31] ? `NFC_ZERO : a1_r); // RULE_11
  wire logic [31:0] mul_f = fmul(a1_r, b1_r); // RULE_12 RULE_13

  wire logic is_sgn = (op1_r == nfc_pkg::NFC_OP_F2SN);
  logic [B-1:0] sc_code;

  nfc_scale #(
    .B(B)
  ) u_scale (
    .f(a1_r),
    .sgn_mode(is_sgn),
    .code(sc_code)
  );

  logic [31:0] fl_nxt;
  logic [B-1:0] cd_nxt;

  always_comb begin
    fl_nxt = `NFC_ZERO;
    cd_nxt = '0;
    case (op1_r)
      nfc_pkg::NFC_OP_UN2F: fl_nxt = un_f;
      nfc_pkg::NFC_OP_SN2F: fl_nxt = sn_f;
      nfc_pkg::NFC_OP_F2UN: cd_nxt = sc_code; // RULE_05
      nfc_pkg::NFC_OP_F2SN: cd_nxt = sc_code; // RULE_07
      nfc_pkg::NFC_OP_SNCL: fl_nxt = cl_f;
      nfc_pkg::NFC_OP_F2UF: fl_nxt = uf_f;
      nfc_pkg::NFC_OP_MUL: fl_nxt = mul_f;
      default: begin
        fl_nxt = `NFC_ZERO;
        cd_nxt = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // output registers; the pipe never stalls, whatever the operands

  always_ff @(posedge CLK) begin
    if (SRST) begin
      OUT_VALID <= 1'b0;
      OUT_FLOAT <= '0;
      OUT_CODE <= '0;
    end else begin
      OUT_VALID <= v1_r; // RULE_16 RULE_17
      OUT_FLOAT <= fl_nxt;
      OUT_CODE <= cd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_latency;
    @(posedge CLK) disable iff (SRST)
    IN_VALID |-> ##2 OUT_VALID;
  endproperty
  a_latency: assert property (p_latency) else $error("valid lost in pipe"); // RULE_17

  property p_no_ghost;
    @(posedge CLK) disable iff (SRST)
    !IN_VALID ##1 1'b1 |=> !OUT_VALID;
  endproperty
  a_no_ghost: assert property (p_no_ghost) else $error("valid without request"); // RULE_17

  property p_un_max;
    @(posedge CLK) disable iff (SRST)
    (IN_VALID && IN_OP == 3'h0 && IN_CODE == UMAX) |-> ##2 (OUT_FLOAT == `NFC_ONE);
  endproperty
  a_un_max: assert property (p_un_max) else $error("unsigned max not 1.0"); // RULE_01

  property p_un_range;
    @(posedge CLK) disable iff (SRST)
    (IN_VALID && IN_OP == 3'h0) |-> ##2 (!OUT_FLOAT[31] && OUT_FLOAT <= `NFC_ONE);
  endproperty
  a_un_range: assert property (p_un_range) else $error("unsigned result out of 0..1"); // RULE_01

  property p_sn_min;
    @(posedge CLK) disable iff (SRST)
    (IN_VALID && IN_OP == 3'h1 && IN_CODE == SMIN) |-> ##2 (OUT_FLOAT == `NFC_NEG_ONE);
  endproperty
  a_sn_min: assert property (p_sn_min) else $error("min code not -1.0"); // RULE_03

  property p_sn_floor;
    @(posedge CLK) disable iff (SRST)
    (IN_VALID && IN_OP == 3'h1) |-> ##2 (OUT_FLOAT[30:0] <= 31'(`NFC_ONE));
  endproperty
  a_sn_floor: assert property (p_sn_floor) else $error("signed result beyond 1.0"); // RULE_02

  property p_cl_floor;
    @(posedge CLK) disable iff (SRST)
    (IN_VALID && IN_OP == 3'h4 && IN_A[31] && IN_A[30:23] != 8'hFF) |->
      ##2 (OUT_FLOAT[30:0] <= 31'(`NFC_ONE));
  endproperty
  a_cl_floor: assert property (p_cl_floor) else $error("clamp let value below -1"); // RULE_04

  property p_f2un_ends;
    @(posedge CLK) disable iff (SRST)
    (IN_VALID && IN_OP == 3'h2 && (IN_A == `NFC_ONE || IN_A[31])) |->
      ##2 (OUT_CODE == ($past(IN_A[31], 2) ? '0 : UMAX));
  endproperty
  a_f2un_ends: assert property (p_f2un_ends) else $error("unsigned end code wrong"); // RULE_05 RULE_06

  property p_f2sn_ends;
    @(posedge CLK) disable iff (SRST)
    (IN_VALID && IN_OP == 3'h3 && IN_A[30:0] == 31'(`NFC_ONE)) |->
      ##2 (OUT_CODE == ($past(IN_A[31], 2) ? SNEG : SMAX));
  endproperty
  a_f2sn_ends: assert property (p_f2sn_ends) else $error("signed end code wrong"); // RULE_07 RULE_08

  property p_uf_neg;
    @(posedge CLK) disable iff (SRST)
    (IN_VALID && IN_OP == 3'h5 && IN_A[31] && !(IN_A[30:23] == 8'hFF && |IN_A[22:0])) |->
      ##2 (OUT_FLOAT == `NFC_ZERO);
  endproperty
  a_uf_neg: assert property (p_uf_neg) else $error("negative not zeroed"); // RULE_11

  property p_mul_zero;
    @(posedge CLK) disable iff (SRST)
    (IN_VALID && IN_OP == 3'h6 && IN_B[30:0] == 31'h0 && IN_A[30:23] != 8'hFF) |->
      ##2 (OUT_FLOAT[30:0] == 31'h0);
  endproperty
  a_mul_zero: assert property (p_mul_zero) else $error("x*0 not zero"); // RULE_13

  property p_mul_one;
    @(posedge CLK) disable iff (SRST)
    (IN_VALID && IN_OP == 3'h6 && IN_B == `NFC_ONE && IN_A[30:23] != 8'h00
      && IN_A[30:23] != 8'hFF) |-> ##2 (OUT_FLOAT == $past(IN_A, 2));
  endproperty
  a_mul_one: assert property (p_mul_one) else $error("x*1 changed x"); // RULE_13

  c_un: cover property (@(posedge CLK) disable iff (SRST) IN_VALID && IN_OP == 3'h0 ##2 OUT_VALID);
  c_sn_min: cover property (@(posedge CLK) disable iff (SRST) IN_VALID && IN_OP == 3'h1 && IN_CODE == SMIN);
  c_f2sn: cover property (@(posedge CLK) disable iff (SRST) IN_VALID && IN_OP == 3'h3 && IN_A[31]);
  c_mul_b2b: cover property (@(posedge CLK) disable iff (SRST) (IN_VALID && IN_OP == 3'h6)[*3]);

endmodule : nfc_top

// [bench/nfc_sink.sv]
// downstream consumer model: collects each result with its arrival time
`timescale 1ns/1ps
module nfc_sink #(
  parameter int B = 8
) (
  input wire logic clk,
  input wire logic valid,
  input wire logic [31:0] flt,
  input wire logic [B-1:0] code
);
  logic [31:0] flt_q[$];
  logic [B-1:0] code_q[$];
  time time_q[$];
  //////////////////////////////////////////////////////////////////////////////
  // mid-cycle sampling; an unknown valid counts as a result so it gets caught
  always @(negedge clk) begin
    if (valid !== 1'b0) begin
      flt_q.push_back(flt);
      code_q.push_back(code);
      time_q.push_back($time);
    end
  end
  function automatic int depth();
    return flt_q.size();
  endfunction : depth
  task automatic take(output logic [31:0] f, output logic [B-1:0] c, output time t);
    f = flt_q.pop_front();
    c = code_q.pop_front();
    t = time_q.pop_front();
  endtask : take
endmodule : nfc_sink

// [bench/tb_nfc_top.sv]
// self-checking bench for the normalized fixed/float converter
`timescale 1ns/1ps
`include "nfc_cfg.svh"
module tb_nfc_top;
  localparam int B = 8;
  // issue and sink sampling both sit on falling edges, so the gap is whole cycles
  localparam int LAT_NS = `NFC_LAT * 10;
  logic CLK = 1'b0;
  logic SRST = 1'b1;
  logic IN_VALID = 1'b0;
  logic [2:0] IN_OP = 3'h7;
  logic [31:0] IN_A = 32'h0;
  logic [31:0] IN_B = 32'h0;
  logic [B-1:0] IN_CODE = 8'h0;
  wire OUT_VALID;
  wire [31:0] OUT_FLOAT;
  wire [B-1:0] OUT_CODE;
  int failures = 0;
  int num_checks = 0;
  logic [31:0] ef_q[$];
  logic [B-1:0] ec_q[$];
  time ti_q[$];
  always #5 CLK = ~CLK;
  nfc_top #(.B(B)) u_nfc_top (.CLK(CLK), .SRST(SRST), .IN_VALID(IN_VALID), .IN_OP(IN_OP), .IN_A(IN_A),
    .IN_B(IN_B), .IN_CODE(IN_CODE), .OUT_VALID(OUT_VALID), .OUT_FLOAT(OUT_FLOAT), .OUT_CODE(OUT_CODE));
  nfc_sink #(.B(B)) u_nfc_sink (.clk(CLK), .valid(OUT_VALID), .flt(OUT_FLOAT), .code(OUT_CODE));
  //////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  task automatic fail_msg(input string m);
    failures++;
    $display("[FAIL] %0t %s", $time, m);
  endtask : fail_msg
  task automatic chk_f(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) fail_msg($sformatf("float got %h exp %h", got, exp));
  endtask : chk_f
  task automatic chk_c(input logic [B-1:0] got, input logic [B-1:0] exp);
    num_checks++;
    if (got !== exp) fail_msg($sformatf("code got %h exp %h", got, exp));
  endtask : chk_c
  task automatic chk_n(input int got, input int exp);
    num_checks++;
    if (got != exp) fail_msg($sformatf("count got %0d exp %0d", got, exp));
  endtask : chk_n
  //////////////////////////////////////////////////////////////////////////////
  // back to back: each call takes the next falling edge, no idle gap
  task automatic issue(input nfc_pkg::nfc_op_t op, input logic [31:0] a, input logic [31:0] b,
                       input logic [B-1:0] c, input logic [31:0] ef, input logic [B-1:0] ec);
    @(negedge CLK);
    IN_VALID = 1'b1;
    IN_OP = op;
    IN_A = a;
    IN_B = b;
    IN_CODE = c;
    ef_q.push_back(ef);
    ec_q.push_back(ec);
    ti_q.push_back($time);
  endtask : issue
  task automatic fo(input nfc_pkg::nfc_op_t op, input logic [31:0] a, input logic [31:0] ef);
    issue(op, a, 32'h3F800000, 8'h00, ef, 8'h00);
  endtask : fo
  task automatic co(input nfc_pkg::nfc_op_t op, input logic [31:0] a, input logic [B-1:0] ec);
    issue(op, a, 32'h0, 8'h00, 32'h0, ec);
  endtask : co
  task automatic drain();
    logic [31:0] f;
    logic [B-1:0] c;
    time t;
    @(negedge CLK);
    IN_VALID = 1'b0;
    IN_OP = nfc_pkg::NFC_OP_NOP;
    repeat (`NFC_LAT + 2) @(negedge CLK);
    #1;
    chk_n(u_nfc_sink.depth(), ef_q.size());
    if (u_nfc_sink.depth() != ef_q.size()) wrap_up();
    while (ef_q.size() > 0) begin
      u_nfc_sink.take(f, c, t);
      chk_f(f, ef_q.pop_front());
      chk_c(c, ec_q.pop_front());
      chk_n(int'(t - ti_q.pop_front()), LAT_NS);
    end
  endtask : drain
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_un2f();
    issue(nfc_pkg::NFC_OP_UN2F, 32'h0, 32'h0, 8'h00, 32'h00000000, 8'h00);
    issue(nfc_pkg::NFC_OP_UN2F, 32'h0, 32'h0, 8'hFF, 32'h3F800000, 8'h00);
    issue(nfc_pkg::NFC_OP_UN2F, 32'h0, 32'h0, 8'h33, 32'h3E4CCCCD, 8'h00);
    drain();
  endtask : t_un2f
  task automatic t_sn2f();
    issue(nfc_pkg::NFC_OP_SN2F, 32'h0, 32'h0, 8'h7F, 32'h3F800000, 8'h00);
    issue(nfc_pkg::NFC_OP_SN2F, 32'h0, 32'h0, 8'h81, 32'hBF800000, 8'h00);
    issue(nfc_pkg::NFC_OP_SN2F, 32'h0, 32'h0, 8'h80, 32'hBF800000, 8'h00);
    issue(nfc_pkg::NFC_OP_SN2F, 32'h0, 32'h0, 8'h00, 32'h00000000, 8'h00);
    drain();
  endtask : t_sn2f
  task automatic t_f2un();
    co(nfc_pkg::NFC_OP_F2UN, 32'h00000000, 8'h00);
    co(nfc_pkg::NFC_OP_F2UN, 32'h3F800000, 8'hFF);
    co(nfc_pkg::NFC_OP_F2UN, 32'h3F000000, 8'h80);
    co(nfc_pkg::NFC_OP_F2UN, 32'hBF800000, 8'h00);
    co(nfc_pkg::NFC_OP_F2UN, 32'h40000000, 8'hFF);
    drain();
  endtask : t_f2un
  task automatic t_f2sn();
    co(nfc_pkg::NFC_OP_F2SN, 32'hBF800000, 8'h81);
    co(nfc_pkg::NFC_OP_F2SN, 32'h00000000, 8'h00);
    co(nfc_pkg::NFC_OP_F2SN, 32'h3F800000, 8'h7F);
    co(nfc_pkg::NFC_OP_F2SN, 32'hC0000000, 8'h81);
    co(nfc_pkg::NFC_OP_F2SN, 32'h3F000000, 8'h40);
    co(nfc_pkg::NFC_OP_F2SN, 32'hBF000000, 8'hC0);
    drain();
  endtask : t_f2sn
  task automatic t_clamps();
    fo(nfc_pkg::NFC_OP_SNCL, 32'hC0000000, 32'hBF800000);
    fo(nfc_pkg::NFC_OP_SNCL, 32'hFF800000, 32'hBF800000);
    fo(nfc_pkg::NFC_OP_SNCL, 32'h3F000000, 32'h3F000000);
    drain();
    fo(nfc_pkg::NFC_OP_F2UF, 32'hBF000000, 32'h00000000);
    fo(nfc_pkg::NFC_OP_F2UF, 32'hFF800000, 32'h00000000);
    fo(nfc_pkg::NFC_OP_F2UF, 32'h7F800000, 32'h7F800000);
    fo(nfc_pkg::NFC_OP_F2UF, 32'h7FC00000, 32'h7FC00000);
    fo(nfc_pkg::NFC_OP_F2UF, 32'h80000000, 32'h00000000);
    drain();
  endtask : t_clamps
  task automatic t_mul();
    issue(nfc_pkg::NFC_OP_MUL, 32'h40400000, 32'h3F800000, 8'h00, 32'h40400000, 8'h00);
    issue(nfc_pkg::NFC_OP_MUL, 32'h40400000, 32'h00000000, 8'h00, 32'h00000000, 8'h00);
    issue(nfc_pkg::NFC_OP_MUL, 32'h00000000, 32'hC0400000, 8'h00, 32'h80000000, 8'h00);
    issue(nfc_pkg::NFC_OP_MUL, 32'h40000000, 32'h40000000, 8'h00, 32'h40800000, 8'h00);
    issue(nfc_pkg::NFC_OP_MUL, 32'h7F000000, 32'h7F000000, 8'h00, 32'h7F800000, 8'h00);
    drain();
  endtask : t_mul
  // specials must still produce one result per operand, never a stall
  task automatic t_special();
    co(nfc_pkg::NFC_OP_F2UN, 32'h7FC00000, 8'h00);
    co(nfc_pkg::NFC_OP_F2SN, 32'hFF800000, 8'h81);
    co(nfc_pkg::NFC_OP_F2UN, 32'h00000001, 8'h00);
    co(nfc_pkg::NFC_OP_F2SN, 32'h80000000, 8'h00);
    issue(nfc_pkg::NFC_OP_MUL, 32'h7F800000, 32'h00000000, 8'h00, 32'h7FC00000, 8'h00);
    co(nfc_pkg::NFC_OP_NOP, 32'h7FC00000, 8'h00);
    drain();
  endtask : t_special
  // reset in flight must drop the pending result
  task automatic t_flush();
    issue(nfc_pkg::NFC_OP_UN2F, 32'h0, 32'h0, 8'hFF, 32'h3F800000, 8'h00);
    @(negedge CLK);
    IN_VALID = 1'b0;
    SRST = 1'b1;
    repeat (2) @(negedge CLK);
    SRST = 1'b0;
    ef_q.delete();
    ec_q.delete();
    ti_q.delete();
    drain();
  endtask : t_flush
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #200us;
    fail_msg("timeout");
    wrap_up();
  end
  initial begin
    repeat (3) @(negedge CLK);
    chk_f({31'h0, OUT_VALID}, 32'h0);
    chk_f(OUT_FLOAT, 32'h0);
    SRST = 1'b0;
    t_un2f();
    t_sn2f();
    t_f2un();
    t_f2sn();
    t_clamps();
    t_mul();
    t_special();
    t_flush();
    t_un2f();
    wrap_up();
  end
endmodule : tb_nfc_top
